/* File: rtl/pcd_cond.sv */
// one power condition: timer settings, flags and idle countdown
module pcd_cond
  import pcd_pkg::*;
#(
  parameter logic SUPPORTED = 1'b1,
  parameter logic SAVABLE = 1'b1,
  parameter logic CHANGEABLE = 1'b1,
  parameter logic DEF_EN = 1'b1,
  parameter logic [31:0] DEF_TIMER = 32'h0000_0001,
  parameter logic [31:0] MIN_TIMER = 32'h0000_0000,
  parameter logic [31:0] MAX_TIMER = 32'h0000_0000
) (
  input wire logic mclk, // block clock
  input wire logic reset_n, // async reset, active low
  pcd_cond_if.cond cif // link to descriptor control
);

  logic [31:0] saved_timer;
  logic saved_en;
  logic [31:0] cur_timer;
  logic cur_en;
  logic [31:0] countdown;
  pcd_tstate_t state;
  logic [31:0] next_saved_timer;
  logic next_saved_en;
  logic [31:0] next_cur_timer;
  logic next_cur_en;
  logic [31:0] next_countdown;
  pcd_tstate_t next_state;
  logic in_range;
  logic accept;
  logic run;

  // set-timer acceptance: zero always allowed, else inside min..max
  assign in_range = (cif.set_value == 32'h0000_0000) ||
    (((MIN_TIMER == 32'h0000_0000) || (cif.set_value >= MIN_TIMER)) &&
     ((MAX_TIMER == 32'h0000_0000) || (cif.set_value <= MAX_TIMER)));
  assign accept = cif.set_req && cif.set_sel && SUPPORTED && CHANGEABLE &&
    cif.feat_en && in_range && (!cif.set_save || SAVABLE);
  assign cif.set_ok = accept;

  // timer only runs with feature on, flag set and nonzero setting
  assign run = cif.feat_en && SUPPORTED && cur_en &&
    (cur_timer != 32'h0000_0000);

  // reported descriptor fields
  always_comb begin
    cif.flags = 8'h00;
    cif.flags[PCD_FLAG_SUPPORTED] = SUPPORTED;
    cif.flags[PCD_FLAG_SAVABLE] = SUPPORTED && SAVABLE;
    cif.flags[PCD_FLAG_CHANGEABLE] = SUPPORTED && CHANGEABLE;
    cif.flags[PCD_FLAG_DEF_EN] = SUPPORTED && DEF_EN;
    cif.flags[PCD_FLAG_SAVED_EN] = SUPPORTED && saved_en;
    cif.flags[PCD_FLAG_CUR_EN] = SUPPORTED && cif.feat_en && cur_en;
  end
  assign cif.saved = SUPPORTED ? saved_timer : 32'h0000_0000;
  assign cif.current = (cif.feat_en && SUPPORTED && cur_en) ?
    cur_timer : 32'h0000_0000;
  assign cif.in_cond = (state == PCD_T_ENTERED);
  assign cif.enter = (state == PCD_T_ARMED) && run && cif.tick &&
    !cif.cmd_done && !accept && (countdown == 32'h0000_0000);

  // next settings and countdown state
  always_comb begin
    next_saved_timer = saved_timer;
    next_saved_en = saved_en;
    next_cur_timer = cur_timer;
    next_cur_en = cur_en;
    next_countdown = countdown;
    next_state = state;
    if (accept) begin
      next_cur_timer = cif.set_value;
      next_cur_en = cif.set_enable;
      if (cif.set_save) begin
        next_saved_timer = cif.set_value;
        next_saved_en = cif.set_enable;
      end
      next_state = PCD_T_IDLE;
    end else if (!run) begin
      next_state = PCD_T_IDLE;
    end else if (cif.cmd_done) begin
      // restart wait; one extra tick covers divider phase
      next_countdown = cur_timer;
      next_state = PCD_T_ARMED;
    end else begin
      case (state)
        PCD_T_IDLE: next_state = PCD_T_IDLE;
        PCD_T_ARMED: begin
          if (cif.tick && cur_timer != PCD_TIMER_INFINITE) begin
            if (countdown == 32'h0000_0000) begin
              next_state = PCD_T_ENTERED;
            end else begin
              next_countdown = countdown - 32'h0000_0001;
            end
          end
        end
        PCD_T_ENTERED: next_state = PCD_T_ENTERED;
        default: next_state = PCD_T_IDLE;
      endcase
    end
  end

  // register settings and countdown
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      saved_timer <= DEF_TIMER;
      saved_en <= DEF_EN;
      cur_timer <= DEF_TIMER;
      cur_en <= DEF_EN;
      countdown <= 32'h0000_0000;
      state <= PCD_T_IDLE;
    end else begin
      saved_timer <= next_saved_timer;
      saved_en <= next_saved_en;
      cur_timer <= next_cur_timer;
      cur_en <= next_cur_en;
      countdown <= next_countdown;
      state <= next_state;
    end
  end

endmodule // pcd_cond

/* File: rtl/pcd_cond_if.sv */
// interface between descriptor control and one power condition
interface pcd_cond_if;
  logic feat_en;
  logic tick;
  logic cmd_done;
  logic set_sel;
  logic set_req;
  logic [31:0] set_value;
  logic set_save;
  logic set_enable;
  logic set_ok;
  logic [7:0] flags;
  logic [31:0] saved;
  logic [31:0] current;
  logic enter;
  logic in_cond;

  modport ctl (
    output feat_en, tick, cmd_done, set_sel, set_req, set_value,
    output set_save, set_enable,
    input set_ok, flags, saved, current, enter, in_cond
  );
  modport cond (
    input feat_en, tick, cmd_done, set_sel, set_req, set_value,
    input set_save, set_enable,
    output set_ok, flags, saved, current, enter, in_cond
  );
endinterface : pcd_cond_if

/* File: rtl/pcd_descriptor.sv */
// power condition descriptor log pages and set-timer control
//
// Overview of operation
// - flags bit 7 reports condition supported
// - savable flag valid only when supported
// - changeable flag valid only when supported
// - flags bit 4 reports default timer enabled
// - flags bit 3 reports saved timer enabled
// - current enable reads zero with feature off
// - bytes 8-11 hold saved timer value
// - timers count 100 ms; all ones means infinite
// - wait current timer after command before entering
// - current timer reads zero in three cases
// - bytes 16-19 nominal recovery, kept over resets
// - bytes 20-23 minimum timer, kept over resets
// - bytes 24-27 maximum timer, kept over resets
// - idle page holds three descriptors from byte 0
// - standby page descriptors start at byte 384
module pcd_descriptor
  import pcd_pkg::*;
#(
  parameter int TICK_CYCLES = PCD_TICK_CYCLES
) (
  input wire logic MCLK, // 125 MHz block clock
  input wire logic RESET_N, // async reset, active low
  input wire logic EXT_POWER_FEATURE, // extended power feature enabled
  input wire logic CMD_DONE, // pulse: a command completed
  input wire logic LOG_RD, // pulse: read one log byte
  input wire logic LOG_PAGE, // 0 idle page, 1 standby page
  input wire logic [8:0] LOG_ADDR, // byte offset inside the page
  output logic [7:0] LOG_DATA, // read byte, registered
  output logic LOG_ACK, // pulse: LOG_DATA valid
  input wire logic SET_REQ, // pulse: set-timer subcommand
  input wire logic [2:0] SET_COND, // condition index 0..4
  input wire logic [31:0] SET_VALUE, // timer value, 100 ms units
  input wire logic SET_SAVE, // also store as saved value
  input wire logic SET_ENABLE, // timer enable with the value
  output logic SET_ACK, // pulse: subcommand finished
  output logic SET_ERR, // with SET_ACK: subcommand refused
  output logic [4:0] ENTER_COND, // pulse: condition i entered
  output logic ACTIVE_POWER_STATE // level: no condition entered
);

  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

  logic [23:0] tick_cnt;
  logic [23:0] next_tick_cnt;
  logic tick;
  logic [7:0] flags_a [PCD_NUM_COND];
  logic [31:0] saved_a [PCD_NUM_COND];
  logic [31:0] current_a [PCD_NUM_COND];
  logic [4:0] set_ok_a;
  logic [4:0] enter_a;
  logic [4:0] in_cond_a;
  logic [7:0] next_log_data;
  logic next_log_ack;
  logic next_set_ack;
  logic next_set_err;
  logic [4:0] next_enter;
  logic next_active;
  logic [2:0] rd_cond;
  logic rd_hit;
  logic [5:0] rd_ofs;
  logic [31:0] rd_word;

  // 100 ms tick divider
  always_comb begin
    tick = (tick_cnt == TICK_LAST);
    next_tick_cnt = tick ? 24'h00_0000 : tick_cnt + 24'h00_0001;
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tick_cnt <= 24'h00_0000;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // one condition instance per descriptor
  genvar gi;
  generate
    for (gi = 0; gi < PCD_NUM_COND; gi++) begin : g_cond
      pcd_cond_if cif ();
      assign cif.feat_en = EXT_POWER_FEATURE;
      assign cif.tick = tick;
      assign cif.cmd_done = CMD_DONE;
      assign cif.set_sel = SET_REQ && (SET_COND == 3'(gi));
      assign cif.set_req = SET_REQ;
      assign cif.set_value = SET_VALUE;
      assign cif.set_save = SET_SAVE;
      assign cif.set_enable = SET_ENABLE;
      assign flags_a[gi] = cif.flags;
      assign saved_a[gi] = cif.saved;
      assign current_a[gi] = cif.current;
      assign set_ok_a[gi] = cif.set_ok;
      assign enter_a[gi] = cif.enter;
      assign in_cond_a[gi] = cif.in_cond;

      pcd_cond #(
        .SUPPORTED(PCD_SUPPORTED[gi]),
        .SAVABLE(PCD_SAVABLE[gi]),
        .CHANGEABLE(PCD_CHANGEABLE[gi]),
        .DEF_EN(PCD_DEF_EN[gi]),
        .DEF_TIMER(PCD_DEF_TIMER[gi]),
        .MIN_TIMER(PCD_MIN_TIMER[gi]),
        .MAX_TIMER(PCD_MAX_TIMER[gi])
      ) u_cond (
        .mclk(MCLK),
        .reset_n(RESET_N),
        .cif(cif)
      );
    end
  endgenerate

  // map page and byte address onto a condition slot
  always_comb begin
    rd_hit = 1'b0;
    rd_cond = PCD_COND_IDLE_A;
    rd_ofs = LOG_ADDR[5:0];
    if (LOG_PAGE == PCD_PAGE_IDLE) begin
      case (LOG_ADDR[8:6])
        PCD_SLOT_IDLE_A: begin
          rd_hit = 1'b1;
          rd_cond = PCD_COND_IDLE_A;
        end
        PCD_SLOT_IDLE_B: begin
          rd_hit = 1'b1;
          rd_cond = PCD_COND_IDLE_B;
        end
        PCD_SLOT_IDLE_C: begin
          rd_hit = 1'b1;
          rd_cond = PCD_COND_IDLE_C;
        end
        default: rd_hit = 1'b0;
      endcase
    end else begin
      case (LOG_ADDR[8:6])
        PCD_SLOT_STBY_Y: begin
          rd_hit = 1'b1;
          rd_cond = PCD_COND_STBY_Y;
        end
        PCD_SLOT_STBY_Z: begin
          rd_hit = 1'b1;
          rd_cond = PCD_COND_STBY_Z;
        end
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // select the dword field and byte, little endian
  always_comb begin
    rd_word = 32'h0000_0000;
    next_log_data = 8'h00;
    if (rd_hit) begin
      case ({rd_ofs[5:2], 2'b00})
        PCD_OFS_SAVED: rd_word = saved_a[rd_cond];
        PCD_OFS_CURRENT: rd_word = current_a[rd_cond];
        PCD_OFS_RECOVERY: rd_word = PCD_RECOVERY[rd_cond];
        PCD_OFS_MIN: rd_word = PCD_MIN_TIMER[rd_cond];
        PCD_OFS_MAX: rd_word = PCD_MAX_TIMER[rd_cond];
        default: rd_word = 32'h0000_0000;
      endcase
      if (rd_ofs == PCD_OFS_FLAGS) begin
        next_log_data = flags_a[rd_cond];
      end else begin
        next_log_data = rd_word[{rd_ofs[1:0], 3'b000} +: 8];
      end
    end
    if (!LOG_RD) begin
      next_log_data = LOG_DATA;
    end
    next_log_ack = LOG_RD;
  end

  // subcommand answer, condition entry and active state
  always_comb begin
    next_set_ack = SET_REQ;
    next_set_err = SET_REQ && (set_ok_a == 5'h00);
    next_enter = enter_a;
    next_active = (in_cond_a == 5'h00) && (enter_a == 5'h00);
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LOG_DATA <= 8'h00;
      LOG_ACK <= 1'b0;
      SET_ACK <= 1'b0;
      SET_ERR <= 1'b0;
      ENTER_COND <= 5'h00;
      ACTIVE_POWER_STATE <= 1'b1;
    end else begin
      LOG_DATA <= next_log_data;
      LOG_ACK <= next_log_ack;
      SET_ACK <= next_set_ack;
      SET_ERR <= next_set_err;
      ENTER_COND <= next_enter;
      ACTIVE_POWER_STATE <= next_active;
    end
  end

endmodule // pcd_descriptor

/* File: rtl/pcd_pkg.sv */
// constants and types shared by the power condition descriptor block
package pcd_pkg;

  // number of power conditions handled: idle a, b, c and standby y, z
  localparam int PCD_NUM_COND = 5;

  // log page selectors
  localparam logic PCD_PAGE_IDLE = 1'b0;
  localparam logic PCD_PAGE_STANDBY = 1'b1;

  // 64-byte descriptor slots inside a 512-byte page (slot = byte addr / 64)
  localparam logic [2:0] PCD_SLOT_IDLE_A = 3'h0;
  localparam logic [2:0] PCD_SLOT_IDLE_B = 3'h1;
  localparam logic [2:0] PCD_SLOT_IDLE_C = 3'h2;
  localparam logic [2:0] PCD_SLOT_STBY_Y = 3'h6;
  localparam logic [2:0] PCD_SLOT_STBY_Z = 3'h7;

  // condition indices used on the set-timer port
  localparam logic [2:0] PCD_COND_IDLE_A = 3'h0;
  localparam logic [2:0] PCD_COND_IDLE_B = 3'h1;
  localparam logic [2:0] PCD_COND_IDLE_C = 3'h2;
  localparam logic [2:0] PCD_COND_STBY_Y = 3'h3;
  localparam logic [2:0] PCD_COND_STBY_Z = 3'h4;

  // byte offsets inside one descriptor
  localparam logic [5:0] PCD_OFS_FLAGS = 6'h01;
  localparam logic [5:0] PCD_OFS_SAVED = 6'h08;
  localparam logic [5:0] PCD_OFS_CURRENT = 6'h0C;
  localparam logic [5:0] PCD_OFS_RECOVERY = 6'h10;
  localparam logic [5:0] PCD_OFS_MIN = 6'h14;
  localparam logic [5:0] PCD_OFS_MAX = 6'h18;

  // flag bit positions
  localparam int PCD_FLAG_SUPPORTED = 7;
  localparam int PCD_FLAG_SAVABLE = 6;
  localparam int PCD_FLAG_CHANGEABLE = 5;
  localparam int PCD_FLAG_DEF_EN = 4;
  localparam int PCD_FLAG_SAVED_EN = 3;
  localparam int PCD_FLAG_CUR_EN = 2;

  // timer value meaning "at or above the largest duration"
  localparam logic [31:0] PCD_TIMER_INFINITE = 32'hFFFF_FFFF;

  // timer unit and clock rate, and the tick divider derived from them
  localparam int PCD_TICK_MS = 100;
  localparam int PCD_CLK_KHZ = 125000;
  localparam int PCD_TICK_CYCLES = PCD_TICK_MS * PCD_CLK_KHZ;

  // per-condition capabilities, bit i = condition i
  localparam logic [4:0] PCD_SUPPORTED = 5'h1F;
  localparam logic [4:0] PCD_SAVABLE = 5'h1F;
  localparam logic [4:0] PCD_CHANGEABLE = 5'h1F;
  localparam logic [4:0] PCD_DEF_EN = 5'h1F;

  // per-condition timer defaults and limits, units of 100 ms
  localparam logic [31:0] PCD_DEF_TIMER [PCD_NUM_COND] =
    '{32'h0000_0001, 32'h0000_0002, 32'h0000_0003,
      32'h0000_0004, 32'h0000_0005};
  localparam logic [31:0] PCD_MIN_TIMER [PCD_NUM_COND] =
    '{32'h0000_0001, 32'h0000_0001, 32'h0000_0001,
      32'h0000_0001, 32'h0000_0001};
  localparam logic [31:0] PCD_MAX_TIMER [PCD_NUM_COND] =
    '{32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF,
      32'h0000_FFFF, 32'h0000_FFFF};
  localparam logic [31:0] PCD_RECOVERY [PCD_NUM_COND] =
    '{32'h0000_0001, 32'h0000_0002, 32'h0000_0003,
      32'h0000_0004, 32'h0000_0005};

  // per-condition idle timer state, gray along idle -> armed -> entered
  typedef enum logic [1:0] {
    PCD_T_IDLE = 2'b00,
    PCD_T_ARMED = 2'b01,
    PCD_T_ENTERED = 2'b11
  } pcd_tstate_t;

endpackage : pcd_pkg

/* File: verification/pcd_descriptor_props.sv */
// port assertions for the power condition descriptor block
module pcd_descriptor_props
  import pcd_pkg::*;
#(
  parameter int TICK_CYCLES = PCD_TICK_CYCLES
) (
  input wire logic MCLK, // clock
  input wire logic RESET_N, // async reset
  input wire logic EXT_POWER_FEATURE, // feature on
  input wire logic CMD_DONE, // command done
  input wire logic LOG_RD, // read pulse
  input wire logic LOG_PAGE, // page select
  input wire logic [8:0] LOG_ADDR, // read address
  input wire logic [7:0] LOG_DATA, // read byte
  input wire logic LOG_ACK, // read answer
  input wire logic SET_REQ, // set pulse
  input wire logic [2:0] SET_COND, // condition
  input wire logic [31:0] SET_VALUE, // timer value
  input wire logic SET_SAVE, // save too
  input wire logic SET_ENABLE, // timer enable
  input wire logic SET_ACK, // set answer
  input wire logic SET_ERR, // set refused
  input wire logic [4:0] ENTER_COND, // entry pulses
  input wire logic ACTIVE_POWER_STATE // active level
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  logic [31:0] since_cmd;
  logic [31:0] next_since_cmd;
  // cycles since the last completed command, saturating
  always_comb begin
    next_since_cmd = since_cmd;
    if (CMD_DONE) next_since_cmd = 32'h0000_0001;
    else if (since_cmd != 32'hFFFF_FFFF) next_since_cmd = since_cmd + 32'h1;
  end
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) since_cmd <= 32'h0000_0000;
    else since_cmd <= next_since_cmd;
  end
  // read request steps seen at the taking edge
  sequence rd_off;
    LOG_RD && !EXT_POWER_FEATURE;
  endsequence
  sequence rd_reserved;
    LOG_RD && (LOG_ADDR[5:0] == 6'h00 || LOG_ADDR[5:1] == 5'h01 ||
               LOG_ADDR[5:0] >= 6'h1C);
  endsequence
  read_answer_a: assert property (LOG_RD |=> LOG_ACK)
    else $error("read not answered next cycle");
  cur_flag_off_a: assert property (rd_off ##0 LOG_ADDR[5:0] == PCD_OFS_FLAGS
    |=> LOG_DATA[PCD_FLAG_CUR_EN] == 1'b0)
    else $error("current enable set with feature off");
  cur_timer_off_a: assert property (rd_off ##0 LOG_ADDR[5:2] == 4'h3
    |=> LOG_DATA == 8'h00)
    else $error("current timer nonzero with feature off");
  reserved_zero_a: assert property (rd_reserved
    |=> LOG_DATA == 8'h00)
    else $error("reserved byte not zero");
  flag_low_a: assert property (LOG_RD && LOG_ADDR[5:0] == PCD_OFS_FLAGS
    |=> LOG_DATA[1:0] == 2'b00)
    else $error("reserved flag bits not zero");
  set_refused_a: assert property (SET_REQ && (!EXT_POWER_FEATURE ||
    SET_COND > 3'h4 || SET_VALUE > PCD_MAX_TIMER[0]) |=> SET_ACK && SET_ERR)
    else $error("bad set request not refused");
  enter_wait_a: assert property (ENTER_COND != 5'h00
    |-> since_cmd > TICK_CYCLES)
    else $error("condition entered too early");
  enter_low_a: assert property (ENTER_COND != 5'h00
    |-> !ACTIVE_POWER_STATE)
    else $error("active level high on entry");
  // active level registers one cycle after the entered state clears
  cmd_wakes_a: assert property (CMD_DONE
    |=> ##1 ACTIVE_POWER_STATE[*2])
    else $error("command did not restore active");
  off_no_enter_a: assert property (!$past(EXT_POWER_FEATURE)
    |-> ENTER_COND == 5'h00)
    else $error("entry with feature off");
endmodule // pcd_descriptor_props

bind pcd_descriptor pcd_descriptor_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .MCLK(MCLK), .RESET_N(RESET_N), .EXT_POWER_FEATURE(EXT_POWER_FEATURE),
  .CMD_DONE(CMD_DONE), .LOG_RD(LOG_RD), .LOG_PAGE(LOG_PAGE),
  .LOG_ADDR(LOG_ADDR), .LOG_DATA(LOG_DATA), .LOG_ACK(LOG_ACK),
  .SET_REQ(SET_REQ), .SET_COND(SET_COND), .SET_VALUE(SET_VALUE),
  .SET_SAVE(SET_SAVE), .SET_ENABLE(SET_ENABLE), .SET_ACK(SET_ACK),
  .SET_ERR(SET_ERR), .ENTER_COND(ENTER_COND),
  .ACTIVE_POWER_STATE(ACTIVE_POWER_STATE)
);

/* File: verification/pcd_descriptor_tb.sv */
// self-checking bench for the descriptor block
module pcd_descriptor_tb
  import pcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICKS = 8;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic feature = 1'b0;
  logic cmd_done = 1'b0;
  logic log_rd, log_page, log_ack, set_req, set_save, set_enable;
  logic set_ack, set_err, active;
  logic [8:0] log_addr;
  logic [7:0] log_data;
  logic [2:0] set_cond;
  logic [31:0] set_value;
  logic [4:0] enter;
  int err_total = 0;
  int compares = 0;
  always #4 mclk = ~mclk;
  pcd_descriptor #(.TICK_CYCLES(TICKS)) uut (
    .MCLK(mclk), .RESET_N(reset_n), .EXT_POWER_FEATURE(feature),
    .CMD_DONE(cmd_done), .LOG_RD(log_rd), .LOG_PAGE(log_page),
    .LOG_ADDR(log_addr), .LOG_DATA(log_data), .LOG_ACK(log_ack),
    .SET_REQ(set_req), .SET_COND(set_cond), .SET_VALUE(set_value),
    .SET_SAVE(set_save), .SET_ENABLE(set_enable), .SET_ACK(set_ack),
    .SET_ERR(set_err), .ENTER_COND(enter), .ACTIVE_POWER_STATE(active)
  );
  pcd_host host (
    .mclk(mclk), .log_data(log_data), .log_ack(log_ack),
    .set_ack(set_ack), .set_err(set_err), .log_rd(log_rd),
    .log_page(log_page), .log_addr(log_addr), .set_req(set_req),
    .set_cond(set_cond), .set_value(set_value), .set_save(set_save),
    .set_enable(set_enable)
  );
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // counts, verdict and stop
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
  endtask
  task automatic set_chk(input logic [2:0] c, input logic [31:0] v,
                         input logic s, input logic en, input logic exp);
    logic e;
    host.settm(c, v, s, en, e);
    check(e, exp);
  endtask
  // defaults with the feature off
  task automatic t_off;
    logic [7:0] b;
    logic [31:0] w;
    check(active, 1'b1);
    host.rd8(1'b0, 9'h001, b);
    w = {PCD_SUPPORTED[0], PCD_SAVABLE[0], PCD_CHANGEABLE[0],
      PCD_DEF_EN[0], PCD_DEF_EN[0], 3'h0};
    check(b, w);
    host.rd32(1'b0, 9'h00C, w);
    check(w, 32'h0000_0000);
    host.rd32(1'b0, 9'h008, w);
    check(w, PCD_DEF_TIMER[0]);
    set_chk(3'h0, 32'h0000_0005, 1'b0, 1'b1, 1'b1);
  endtask
  // accepted and refused subcommands on idle b, and one refused on condition index 5
  task automatic t_set;
    logic [7:0] b;
    logic [31:0] w;
    feature <= 1'b1;
    set_chk(3'h1, 32'h0000_0005, 1'b1, 1'b1, 1'b0);
    host.rd32(1'b0, 9'h04C, w);
    check(w, 32'h0000_0005);
    set_chk(3'h1, 32'h0000_0007, 1'b0, 1'b0, 1'b0);
    host.rd8(1'b0, 9'h041, b);
    check(b[2], 1'b0);
    host.rd32(1'b0, 9'h04C, w);
    check(w, 32'h0000_0000);
    host.rd32(1'b0, 9'h048, w);
    check(w, 32'h0000_0005);
    set_chk(3'h1, PCD_MAX_TIMER[1] + 32'h1, 1'b0, 1'b1, 1'b1);
    set_chk(3'h1, PCD_MAX_TIMER[1], 1'b0, 1'b1, 1'b0);
    set_chk(3'h5, 32'h0000_0005, 1'b0, 1'b1, 1'b1);
    host.rd32(1'b0, 9'h04C, w);
    check(w, PCD_MAX_TIMER[1]);
    feature <= 1'b0;
    host.rd32(1'b0, 9'h04C, w);
    check(w, 32'h0000_0000);
  endtask
  // idle a entry after two timer units
  task automatic t_timer;
    int n;
    feature <= 1'b1;
    set_chk(3'h0, 32'h0000_0002, 1'b0, 1'b1, 1'b0);
    @(posedge mclk);
    cmd_done <= 1'b1;
    @(posedge mclk);
    cmd_done <= 1'b0;
    n = 0;
    while (n < 6 * TICKS && enter[0] !== 1'b1) begin
      @(posedge mclk);
      n++;
    end
    check(32'(n >= 2 * TICKS && n <= 3 * TICKS + 2), 32'h1);
    check(active, 1'b0);
    @(posedge mclk);
    cmd_done <= 1'b1;
    @(posedge mclk);
    cmd_done <= 1'b0;
    // entered state clears at the taking edge, active one edge later
    repeat (2) @(posedge mclk);
    check(active, 1'b1);
  endtask
  // every descriptor after a second reset
  task automatic t_table;
    logic [7:0] b;
    logic [31:0] w;
    logic pg;
    logic [8:0] a;
    feature <= 1'b1;
    for (int i = 0; i < PCD_NUM_COND; i++) begin
      pg = (i > 2);
      a = (i > 2) ? 9'((i + 3) * 64) : 9'(i * 64);
      host.rd8(pg, a + 9'h001, b);
      w = {PCD_SUPPORTED[i], PCD_SAVABLE[i], PCD_CHANGEABLE[i],
        {3{PCD_DEF_EN[i]}}};
      check(b[7:2], w);
      host.rd32(pg, a + 9'h008, w);
      check(w, PCD_DEF_TIMER[i]);
      host.rd32(pg, a + 9'h010, w);
      check(w, PCD_RECOVERY[i]);
      host.rd32(pg, a + 9'h014, w);
      check(w, PCD_MIN_TIMER[i]);
      host.rd32(pg, a + 9'h018, w);
      check(w, PCD_MAX_TIMER[i]);
      host.rd8(pg, a + 9'h003, b);
      check(b, 8'h00);
      host.rd8(pg, a + 9'h03F, b);
      check(b, 8'h00);
    end
    host.rd8(1'b0, 9'h0C1, b);
    check(b, 8'h00);
    host.rd8(1'b1, 9'h001, b);
    check(b, 8'h00);
  endtask
  initial begin
    do_reset;
    t_off;
    t_set;
    t_timer;
    do_reset;
    t_table;
    end_of_test;
  end
  // hang guard
  initial begin
    #200000;
    err_total++;
    end_of_test;
  end
endmodule // pcd_descriptor_tb

/* File: verification/pcd_host.sv */
// host model: log byte reads and set-timer subcommands
module pcd_host (
  input wire logic mclk, // block clock
  input wire logic [7:0] log_data, // read byte
  input wire logic log_ack, // read answer
  input wire logic set_ack, // set answer
  input wire logic set_err, // set refused
  output logic log_rd, // read pulse
  output logic log_page, // page select
  output logic [8:0] log_addr, // byte address
  output logic set_req, // set pulse
  output logic [2:0] set_cond, // condition index
  output logic [31:0] set_value, // timer value
  output logic set_save, // save too
  output logic set_enable // timer enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet bus at time zero
  initial begin
    {log_rd, log_page, log_addr, set_req, set_cond} = '0;
    {set_value, set_save, set_enable} = '0;
  end
  // one byte read; data is the last sampled log_data byte if never answered
  task automatic rd8(input logic pg, input logic [8:0] a,
                     output logic [7:0] d);
    logic got;
    got = 1'b0;
    d = 'x;
    @(posedge mclk);
    log_rd <= 1'b1;
    log_page <= pg;
    log_addr <= a;
    @(posedge mclk);
    log_rd <= 1'b0;
    for (int i = 0; i < 4 && !got; i++) begin
      @(posedge mclk);
      got = log_ack;
      d = log_data;
    end
  endtask
  // dword fields are little endian
  task automatic rd32(input logic pg, input logic [8:0] a,
                      output logic [31:0] w);
    logic [7:0] b;
    for (int k = 0; k < 4; k++) begin
      rd8(pg, a + 9'(k), b);
      w[8*k +: 8] = b;
    end
  endtask
  // one subcommand; err is the last sampled set_err if never answered
  task automatic settm(input logic [2:0] c, input logic [31:0] v,
                       input logic s, input logic en, output logic err);
    logic got;
    got = 1'b0;
    err = 'x;
    @(posedge mclk);
    set_req <= 1'b1;
    {set_cond, set_value, set_save, set_enable} <= {c, v, s, en};
    @(posedge mclk);
    set_req <= 1'b0;
    for (int i = 0; i < 4 && !got; i++) begin
      @(posedge mclk);
      got = set_ack;
      err = set_err;
    end
  endtask
endmodule // pcd_host
